// File: src/hims_consts.vh
// Constants shared by the host interface mode select block.
`ifndef HIMS_CONSTS_VH
`define HIMS_CONSTS_VH

// Decoded host port modes.
`define HIMS_MODE_8080 3'h0
`define HIMS_MODE_6800 3'h1
`define HIMS_MODE_SPI3 3'h2
`define HIMS_MODE_SPI4 3'h3
`define HIMS_MODE_I2C_NC 3'h4
`define HIMS_MODE_I2C_C 3'h5
`define HIMS_MODE_NONE 3'h7

// Select pin patterns; bit 0 is ignored for the parallel modes.
`define HIMS_SEL_PAR_HI 2'h0
`define HIMS_SEL_6800_HI 2'h1
`define HIMS_SEL_SPI3 3'h4
`define HIMS_SEL_SPI4 3'h5
`define HIMS_SEL_I2C_NC 3'h6
`define HIMS_SEL_I2C_C 3'h7

// Field positions of the data bus.
`define HIMS_DB_LO_MSB 7
`define HIMS_DB_HI_LSB 8

// Reset values.
`define HIMS_MODE_RST 3'h7
`define HIMS_DATA_RST 16'h0000
`define HIMS_PLL_M_RST 8'h10
`define HIMS_PLL_N_RST 8'h01
`define HIMS_PLL_OD_RST 8'h02
`define HIMS_FOUT_RST 24'h000000

// Crystal reference in kHz, used for the output frequency readback.
`define HIMS_XTAL_KHZ 32'd12000

`endif

// File: src/hims_par_port.v
// Parallel 8080 / 6800 host port strobe engine.
`include "hims_consts.vh"

module hims_par_port (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Configuration
    input wire i_enable,
    input wire i_mode_6800,
    input wire i_wide16,
    // Synchronised pins
    input wire i_cs_n,
    input wire i_wr_n,
    input wire i_rd_n,
    input wire i_a0,
    input wire [15:0] i_din,
    // Access port
    output reg o_req,
    output reg o_we,
    output reg o_cmd,
    output reg [15:0] o_wdata,
    input wire i_rvalid,
    input wire [15:0] i_rdata,
    // Pin drive
    output reg [15:0] o_dout,
    output wire o_drive
);

    reg wr_d1_q;
    reg rd_d1_q;
    wire sel;
    wire wr_done;
    wire rd_start;
    wire [15:0] din_w;

    assign sel = i_enable & ~i_cs_n;
    assign din_w = i_wide16 ? i_din : {8'h00, i_din[`HIMS_DB_LO_MSB:0]};

    // In 6800 style the read pin is the enable strobe and the write pin is read/not-write.
    assign wr_done = i_mode_6800 ? (rd_d1_q & ~i_rd_n & ~i_wr_n) : (~wr_d1_q & i_wr_n);
    assign rd_start = i_mode_6800 ? (~rd_d1_q & i_rd_n & i_wr_n) : (rd_d1_q & ~i_rd_n);
    assign o_drive = sel & (i_mode_6800 ? (i_rd_n & i_wr_n) : ~i_rd_n);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_d1_q <= 1'b1;
            rd_d1_q <= 1'b1;
            o_req <= 1'b0;
            o_we <= 1'b0;
            o_cmd <= 1'b0;
            o_wdata <= `HIMS_DATA_RST;
            o_dout <= `HIMS_DATA_RST;
        end else begin
            wr_d1_q <= i_wr_n;
            rd_d1_q <= i_rd_n;
            o_req <= sel & (wr_done | rd_start);
            if (sel & (wr_done | rd_start)) begin
                o_we <= wr_done;
                o_cmd <= i_a0;
                o_wdata <= din_w;
            end
            if (i_rvalid) begin
                o_dout <= i_wide16 ? i_rdata : {8'h00, i_rdata[`HIMS_DB_LO_MSB:0]};
            end
        end
    end

endmodule

// File: src/hims_top.v
// Host interface mode select: strap decode, pin sharing, access mux and PLL settings.
//
// Functional notes
// - Select pins 0,0,x choose 8080 parallel port, 8 or 16 bits.
// - Select pins 0,1,x choose 6800 parallel port, 8 or 16 bits.
// - Select pins 1,0,0 choose 3-wire SPI slave.
// - Select pins 1,0,1 choose 4-wire SPI; only this mode allows by-pass.
// - Select pins 1,1,0 choose I2C slave without continuous reads.
// - Select pins 1,1,1 choose I2C slave with continuous reads.
// - Host reads and writes registers and display memory in every mode.
// - Host port runs on the core clock, 96 MHz from 12 MHz.
// - Each PLL has own settings; output is reference times M over N over OD.
// - Reduced build keeps only 8080 and SPI modes.
// - High data byte becomes general I/O only in 8-bit or serial modes.
// - In serial modes the parallel control pins are general inputs.
`include "hims_consts.vh"

module hims_top #(
    parameter REDUCED_PORT = 0,
    parameter NUM_PLL = 3
) (
    // Clock and reset
    input wire I_SYS_CLK,
    input wire I_RST_N,
    // Straps and width
    input wire [2:0] I_HOST_IFACE_SELECT_PINS,
    input wire I_PAR_WIDE16,
    // Parallel control pins
    input wire I_CS_N,
    input wire I_WR_N,
    input wire I_RD_N,
    input wire I_CMD_DATA_SELECT,
    // Data bus pins
    input wire [15:0] I_DB_IN,
    output wire [15:0] O_DB_OUT,
    output wire [15:0] O_DB_OE,
    // General purpose I/O sharing
    input wire [7:0] I_GP_IO_PORT_A_OUT,
    input wire [7:0] I_GP_IO_PORT_A_OE,
    output reg [7:0] O_GP_IO_PORT_A_IN,
    output reg [3:0] O_GP_IO_PORT_B_LOW_IN,
    output wire O_GP_IO_HIGH_FREE,
    // Mode status
    output reg [2:0] O_MODE,
    output reg O_MODE_VALID,
    output reg O_MODE_UNSUPPORTED,
    output reg O_SPI_BYPASS_ALLOWED,
    output reg O_I2C_CONT_READ_EN,
    // Serial engine access port
    input wire I_SER_REQ,
    input wire I_SER_WE,
    input wire I_SER_CMD,
    input wire [15:0] I_SER_WDATA,
    output reg [15:0] O_SER_RDATA,
    output reg O_SER_RVALID,
    // Register and display memory access
    output reg O_ACC_REQ,
    output reg O_ACC_WE,
    output reg O_ACC_CMD,
    output reg [15:0] O_ACC_WDATA,
    input wire [15:0] I_ACC_RDATA,
    // PLL settings
    input wire [NUM_PLL-1:0] I_PLL_LOAD,
    input wire [7:0] I_PLL_M,
    input wire [7:0] I_PLL_N,
    input wire [7:0] I_PLL_OD,
    output wire [NUM_PLL*8-1:0] O_PLL_M,
    output wire [NUM_PLL*8-1:0] O_PLL_N,
    output wire [NUM_PLL*8-1:0] O_PLL_OUTPUT_DIVIDER,
    output wire [NUM_PLL*24-1:0] O_PLL_FOUT_KHZ
);

    function is_parallel;
        input [2:0] m;
        begin
            is_parallel = (m == `HIMS_MODE_8080) || (m == `HIMS_MODE_6800);
        end
    endfunction

    function is_serial;
        input [2:0] m;
        begin
            is_serial = (m >= `HIMS_MODE_SPI3) && (m <= `HIMS_MODE_I2C_C);
        end
    endfunction

    function [23:0] pll_fout;
        input [7:0] m;
        input [7:0] n;
        input [7:0] od;
        reg [31:0] prod;
        reg [31:0] q;
        begin
            prod = `HIMS_XTAL_KHZ * {24'h000000, m};
            q = 32'h00000000;
            if ((n != 8'h00) && (od != 8'h00)) begin
                q = (prod / {24'h000000, n}) / {24'h000000, od};
            end
            pll_fout = q[23:0];
        end
    endfunction

    // Two-stage synchronisers for the select, control and data bus pins; I_PAR_WIDE16 is used unsynchronised.
    reg [2:0] sel_s1_q;
    reg [2:0] sel_s2_q;
    reg [3:0] ctl_s1_q;
    reg [3:0] ctl_s2_q;
    reg [15:0] db_s1_q;
    reg [15:0] db_s2_q;

    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sel_s1_q <= 3'h0;
            sel_s2_q <= 3'h0;
            ctl_s1_q <= 4'hf;
            ctl_s2_q <= 4'hf;
            db_s1_q <= `HIMS_DATA_RST;
            db_s2_q <= `HIMS_DATA_RST;
        end else begin
            sel_s1_q <= I_HOST_IFACE_SELECT_PINS;
            sel_s2_q <= sel_s1_q;
            ctl_s1_q <= {I_CMD_DATA_SELECT, I_WR_N, I_RD_N, I_CS_N};
            ctl_s2_q <= ctl_s1_q;
            db_s1_q <= I_DB_IN;
            db_s2_q <= db_s1_q;
        end
    end

    // Strap decode.
    reg [2:0] mode_d;
    always @* begin
        if (sel_s2_q[2:1] == `HIMS_SEL_PAR_HI) begin
            mode_d = `HIMS_MODE_8080;
        end else if (sel_s2_q[2:1] == `HIMS_SEL_6800_HI) begin
            mode_d = `HIMS_MODE_6800;
        end else begin
            case (sel_s2_q)
                `HIMS_SEL_SPI3: mode_d = `HIMS_MODE_SPI3;
                `HIMS_SEL_SPI4: mode_d = `HIMS_MODE_SPI4;
                `HIMS_SEL_I2C_NC: mode_d = `HIMS_MODE_I2C_NC;
                `HIMS_SEL_I2C_C: mode_d = `HIMS_MODE_I2C_C;
                default: mode_d = `HIMS_MODE_NONE;
            endcase
        end
    end

    wire unsupported;
    assign unsupported = (REDUCED_PORT != 0) &&
        ((mode_d == `HIMS_MODE_6800) || (mode_d == `HIMS_MODE_I2C_NC) ||
         (mode_d == `HIMS_MODE_I2C_C));

    // The straps are caught once, after the synchronisers have filled behind the
    // reset release; later strap changes cannot disturb a running host port.
    reg [1:0] fill_q;
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fill_q <= 2'h0;
            O_MODE <= `HIMS_MODE_RST;
            O_MODE_VALID <= 1'b0;
            O_MODE_UNSUPPORTED <= 1'b0;
            O_SPI_BYPASS_ALLOWED <= 1'b0;
            O_I2C_CONT_READ_EN <= 1'b0;
        end else begin
            if (fill_q != 2'h3) begin
                fill_q <= fill_q + 2'h1;
            end
            if ((fill_q == 2'h2) && !O_MODE_VALID) begin
                O_MODE_VALID <= 1'b1;
                O_MODE_UNSUPPORTED <= unsupported;
                O_MODE <= unsupported ? `HIMS_MODE_NONE : mode_d;
                O_SPI_BYPASS_ALLOWED <= (mode_d == `HIMS_MODE_SPI4);
                O_I2C_CONT_READ_EN <= !unsupported && (mode_d == `HIMS_MODE_I2C_C);
            end
        end
    end

    wire par_mode;
    wire ser_mode;
    assign par_mode = O_MODE_VALID && is_parallel(O_MODE);
    assign ser_mode = O_MODE_VALID && is_serial(O_MODE);

    // Parallel engine.
    wire par_req;
    wire par_we;
    wire par_cmd;
    wire [15:0] par_wdata;
    wire [15:0] par_dout;
    wire par_drive;
    reg acc_rvalid_q;

    hims_par_port u_par (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_enable(par_mode),
        .i_mode_6800(O_MODE == `HIMS_MODE_6800),
        .i_wide16(I_PAR_WIDE16),
        .i_cs_n(ctl_s2_q[0]),
        .i_wr_n(ctl_s2_q[2]),
        .i_rd_n(ctl_s2_q[1]),
        .i_a0(ctl_s2_q[3]),
        .i_din(db_s2_q),
        .o_req(par_req),
        .o_we(par_we),
        .o_cmd(par_cmd),
        .o_wdata(par_wdata),
        .i_rvalid(acc_rvalid_q & par_mode),
        .i_rdata(I_ACC_RDATA),
        .o_dout(par_dout),
        .o_drive(par_drive)
    );

    // Access mux; read data is expected one cycle after a read request.
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ACC_REQ <= 1'b0;
            O_ACC_WE <= 1'b0;
            O_ACC_CMD <= 1'b0;
            O_ACC_WDATA <= `HIMS_DATA_RST;
            acc_rvalid_q <= 1'b0;
            O_SER_RDATA <= `HIMS_DATA_RST;
            O_SER_RVALID <= 1'b0;
        end else begin
            if (par_mode) begin
                O_ACC_REQ <= par_req;
                O_ACC_WE <= par_we;
                O_ACC_CMD <= par_cmd;
                O_ACC_WDATA <= par_wdata;
            end else begin
                O_ACC_REQ <= ser_mode & I_SER_REQ;
                O_ACC_WE <= I_SER_WE;
                O_ACC_CMD <= I_SER_CMD;
                O_ACC_WDATA <= I_SER_WDATA;
            end
            acc_rvalid_q <= O_ACC_REQ & ~O_ACC_WE;
            O_SER_RVALID <= acc_rvalid_q & ser_mode;
            if (acc_rvalid_q & ser_mode) begin
                O_SER_RDATA <= I_ACC_RDATA;
            end
        end
    end

    assign O_GP_IO_HIGH_FREE = ser_mode || (par_mode && !I_PAR_WIDE16);

    wire [7:0] hi_oe;
    assign hi_oe = O_GP_IO_HIGH_FREE ? I_GP_IO_PORT_A_OE : {8{par_drive}};
    assign O_DB_OUT = {O_GP_IO_HIGH_FREE ? I_GP_IO_PORT_A_OUT : par_dout[15:8], par_dout[7:0]};
    assign O_DB_OE = {hi_oe, {8{par_drive}}};

    // General purpose inputs read the synchronised pins.
    always @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_GP_IO_PORT_A_IN <= 8'h00;
            O_GP_IO_PORT_B_LOW_IN <= 4'h0;
        end else begin
            O_GP_IO_PORT_A_IN <= O_GP_IO_HIGH_FREE ? db_s2_q[15:`HIMS_DB_HI_LSB] : 8'h00;
            O_GP_IO_PORT_B_LOW_IN <= ser_mode ? ctl_s2_q : 4'h0;
        end
    end

    // this whole block is clocked by core_clk, applied on I_SYS_CLK.
    // PLL setting groups, one per PLL.
    genvar g;
    generate
        for (g = 0; g < NUM_PLL; g = g + 1) begin : g_pll
            reg [7:0] m_q;
            reg [7:0] n_q;
            reg [7:0] od_q;
            reg [23:0] fout_q;
            always @(posedge I_SYS_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    m_q <= `HIMS_PLL_M_RST;
                    n_q <= `HIMS_PLL_N_RST;
                    od_q <= `HIMS_PLL_OD_RST;
                    fout_q <= `HIMS_FOUT_RST;
                end else begin
                    if (I_PLL_LOAD[g]) begin
                        m_q <= I_PLL_M;
                        n_q <= I_PLL_N;
                        od_q <= I_PLL_OD;
                    end
                    fout_q <= pll_fout(m_q, n_q, od_q);
                end
            end
            assign O_PLL_M[g*8 +: 8] = m_q;
            assign O_PLL_N[g*8 +: 8] = n_q;
            assign O_PLL_OUTPUT_DIVIDER[g*8 +: 8] = od_q;
            assign O_PLL_FOUT_KHZ[g*24 +: 24] = fout_q;
        end
    endgenerate

endmodule

// File: tb/hims_chk.sv
// Assertion checker on the host interface mode select top ports.
module hims_chk #(
    parameter NUM_PLL = 3
) (
    // Clock, reset and straps
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic [2:0] I_HOST_IFACE_SELECT_PINS,
    input wire logic I_PAR_WIDE16,
    // Status and access
    input wire logic O_GP_IO_HIGH_FREE,
    input wire logic [2:0] O_MODE,
    input wire logic O_MODE_VALID,
    input wire logic O_SPI_BYPASS_ALLOWED,
    input wire logic O_I2C_CONT_READ_EN,
    input wire logic I_SER_REQ,
    input wire logic I_SER_WE,
    input wire logic [15:0] I_SER_WDATA,
    input wire logic O_ACC_REQ,
    input wire logic O_ACC_WE,
    input wire logic [15:0] O_ACC_WDATA,
    input wire logic O_SER_RVALID,
    // PLL settings
    input wire logic [NUM_PLL-1:0] I_PLL_LOAD,
    input wire logic [7:0] I_PLL_M,
    input wire logic [7:0] I_PLL_N,
    input wire logic [7:0] I_PLL_OD,
    input wire logic [NUM_PLL*8-1:0] O_PLL_M,
    input wire logic [NUM_PLL*24-1:0] O_PLL_FOUT_KHZ
);
    wire logic [2:0] sel = I_HOST_IFACE_SELECT_PINS;
    wire logic ser = O_MODE_VALID && O_MODE > 3'h1 && O_MODE < 3'h6;
    // A zero divider must give zero, not an unknown.
    wire logic [31:0] fe = (I_PLL_N == 8'h0 || I_PLL_OD == 8'h0) ? 32'h0 :
        32'd12000 * I_PLL_M / I_PLL_N / I_PLL_OD;
    default clocking @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);
    a_sel_par: assert property (
        $rose(O_MODE_VALID) && !sel[2] |-> O_MODE == {2'h0, sel[1]})
        else $error("Parallel mode decode wrong.");
    a_sel_spi: assert property (
        $rose(O_MODE_VALID) && sel[2:1] == 2'h2 |->
        O_MODE == 3'h2 + sel[0] && O_SPI_BYPASS_ALLOWED == sel[0])
        else $error("SPI mode decode wrong.");
    a_sel_i2c: assert property (
        $rose(O_MODE_VALID) && sel[2:1] == 2'h3 |->
        O_MODE == 3'h4 + sel[0] && O_I2C_CONT_READ_EN == sel[0])
        else $error("I2C mode decode wrong.");
    a_mode_hold: assert property (
        O_MODE_VALID |=> O_MODE_VALID && $stable(O_MODE))
        else $error("Mode changed without reset.");
    a_valid_time: assert property (
        $rose(I_RST_N) |-> ##[1:4] O_MODE_VALID)
        else $error("Mode not latched after reset.");
    a_high_free: assert property (
        O_MODE_VALID && O_MODE != 3'h7 |->
        O_GP_IO_HIGH_FREE == (O_MODE > 3'h1 || !I_PAR_WIDE16))
        else $error("High byte release wrong.");
    a_ser_acc: assert property (
        I_SER_REQ && ser |=> O_ACC_REQ && O_ACC_WE == $past(I_SER_WE) &&
        O_ACC_WDATA == $past(I_SER_WDATA))
        else $error("Serial access not passed on.");
    a_ser_read: assert property (
        I_SER_REQ && !I_SER_WE && ser |-> ##3 O_SER_RVALID)
        else $error("Serial read data missing.");
    a_pll_load: assert property (
        I_PLL_LOAD[0] |=> O_PLL_M[7:0] == $past(I_PLL_M) &&
        ($past(I_PLL_LOAD[1]) || $stable(O_PLL_M[15:8])))
        else $error("PLL settings not independent.");
    a_pll_fout: assert property (
        I_PLL_LOAD[0] |-> ##2 O_PLL_FOUT_KHZ[23:0] == $past(fe[23:0], 2))
        else $error("PLL output frequency wrong.");
endmodule

bind hims_top hims_chk #(.NUM_PLL(NUM_PLL)) u_chk (
    .I_SYS_CLK, .I_RST_N, .I_HOST_IFACE_SELECT_PINS, .I_PAR_WIDE16,
    .O_GP_IO_HIGH_FREE, .O_MODE, .O_MODE_VALID, .O_SPI_BYPASS_ALLOWED,
    .O_I2C_CONT_READ_EN, .I_SER_REQ, .I_SER_WE, .I_SER_WDATA, .O_ACC_REQ,
    .O_ACC_WE, .O_ACC_WDATA, .O_SER_RVALID, .I_PLL_LOAD, .I_PLL_M, .I_PLL_N,
    .I_PLL_OD, .O_PLL_M, .O_PLL_FOUT_KHZ
);

// File: tb/hims_host_mdl.sv
// Behavioural host microcontroller on the parallel port pins.
module hims_host_mdl (
    // Clock and bus setup
    input wire logic i_clk,
    input wire logic i_m6800,
    input wire logic i_wide16,
    // Port pins
    output logic o_cs_n = 1'b1,
    output logic o_wr_n = 1'b1,
    output logic o_rd_n = 1'b1,
    output logic o_a0 = 1'b0,
    output wire logic [15:0] o_db,
    input wire logic [15:0] i_db_out,
    input wire logic [15:0] i_db_oe
);
    logic drv = 1'b0;
    logic [15:0] dat = 16'h0;
    logic [15:0] flt = 16'h5a5a;
    // Released lines flip every cycle so stale data is never taken as valid.
    always @(posedge i_clk) flt <= ~flt;
    // low byte only at 8-bit width
    wire logic [15:0] hm = drv ? (i_wide16 ? 16'hffff : 16'h00ff) : 16'h0;
    assign o_db = (i_db_oe & i_db_out) | (~i_db_oe & ((hm & dat) | (~hm & flt)));
    task park(input logic m);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_rd_n <= !m;
    endtask
    task pins(input logic [3:0] v);
        {o_a0, o_wr_n, o_rd_n, o_cs_n} <= v;
    endtask
    // one register or memory access, every level held well past the sync delay
    task acc(input logic we, input logic cmd, input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_a0 <= cmd;
        dat <= d;
        drv <= we;
        o_wr_n <= !(i_m6800 && we);
        repeat (4) @(posedge i_clk);
        o_wr_n <= !we;
        o_rd_n <= i_m6800 || we;
        repeat (12) @(posedge i_clk);
        q = o_db;
        o_rd_n <= !i_m6800;
        // Direction must not move at the edge that ends a 6800 write.
        o_wr_n <= o_wr_n | !i_m6800;
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        drv <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// File: tb/hims_top_tb_top.sv
// Self-checking testbench for the host interface mode select block.
module hims_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n = 0, wide = 0, sreq = 0, swe = 0, scmd = 0, m68 = 0;
    logic [2:0] sel = 0, pld = 0;
    logic [15:0] swd = 0, ard = 0, q, d;
    logic [7:0] gao = 0, gaoe = 0, pm = 0, pn = 0, pod = 0;
    wire logic cs_n, wr_n, rd_n, a0, hfree, mval, unsup, byp, cont, srv, areq, awe, acmd;
    wire logic [2:0] mode;
    wire logic [3:0] gpb;
    wire logic [7:0] gpa;
    wire logic [15:0] dbi, dbo, dboe, srd, awd;
    wire logic [23:0] opm, opn, opod;
    wire logic [71:0] fout;
    integer miscompares = 0, cmp_count = 0, seed = 1, s, g;
    hims_host_mdl host (.i_clk(clk), .i_m6800(m68), .i_wide16(wide), .o_cs_n(cs_n),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_a0(a0), .o_db(dbi), .i_db_out(dbo), .i_db_oe(dboe));
    hims_top uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HOST_IFACE_SELECT_PINS(sel),
        .I_PAR_WIDE16(wide), .I_CS_N(cs_n), .I_WR_N(wr_n), .I_RD_N(rd_n),
        .I_CMD_DATA_SELECT(a0), .I_DB_IN(dbi), .O_DB_OUT(dbo), .O_DB_OE(dboe),
        .I_GP_IO_PORT_A_OUT(gao), .I_GP_IO_PORT_A_OE(gaoe), .O_GP_IO_PORT_A_IN(gpa),
        .O_GP_IO_PORT_B_LOW_IN(gpb), .O_GP_IO_HIGH_FREE(hfree), .O_MODE(mode),
        .O_MODE_VALID(mval), .O_MODE_UNSUPPORTED(unsup), .O_SPI_BYPASS_ALLOWED(byp),
        .O_I2C_CONT_READ_EN(cont), .I_SER_REQ(sreq), .I_SER_WE(swe), .I_SER_CMD(scmd),
        .I_SER_WDATA(swd), .O_SER_RDATA(srd), .O_SER_RVALID(srv), .O_ACC_REQ(areq),
        .O_ACC_WE(awe), .O_ACC_CMD(acmd), .O_ACC_WDATA(awd), .I_ACC_RDATA(ard),
        .I_PLL_LOAD(pld), .I_PLL_M(pm), .I_PLL_N(pn), .I_PLL_OD(pod), .O_PLL_M(opm),
        .O_PLL_N(opn), .O_PLL_OUTPUT_DIVIDER(opod), .O_PLL_FOUT_KHZ(fout));
    function automatic logic [2:0] emode(input logic [2:0] v);
        return v[2] ? (v[1] ? 3'h4 : 3'h2) + v[0] : {2'h0, v[1]};
    endfunction
    function automatic logic [31:0] efout(input logic [7:0] m, n, od);
        return (n == 0 || od == 0) ? 32'h0 : 32'd12000 * m / n / od;
    endfunction
    task automatic cmp(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for mode latch (1) or an access request (0).
    task automatic wait_on(input int v);
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            if ((v ? mval : areq) === 1'b1) return;
        end
        miscompares++;
        tally_and_finish;
    endtask
    task automatic do_reset(input logic [2:0] v, input int n);
        @(posedge clk);
        rst_n <= 0;
        sel <= v;
        wide <= 1'($random(seed));
        m68 = v[2:1] == 2'h1;
        host.park(m68);
        repeat (n) @(posedge clk);
        rst_n <= 1;
        wait_on(1);
    endtask
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        for (s = 0; s < 8; s++) begin
            do_reset(s[2:0], s == 0 ? 4 : 34);
            cmp(mode, emode(s[2:0]));
            cmp({byp, cont}, {s == 5, s == 7});
            cmp(unsup, 0);
            if (s == 0) cmp(fout[23:0], 96000);
            d = $random(seed);
            @(posedge clk);
            ard <= $random(seed);
            gao <= $random(seed);
            gaoe <= $random(seed);
            if (s < 4) begin
                fork
                    host.acc(1, d[2], d, q);
                    wait_on(0);
                join
                cmp({awe, acmd, awd}, {1'b1, d[2], wide ? d : {8'h0, d[7:0]}});
                fork
                    host.acc(0, d[3], 16'h0, q);
                    wait_on(0);
                join
                cmp(awe, 0);
                cmp(q & (wide ? 16'hffff : 16'h00ff), ard & (wide ? 16'hffff : 16'h00ff));
                cmp(hfree, !wide);
                cmp(gpa & (wide ? 8'hff : gaoe), wide ? 8'h00 : gao & gaoe);
                @(posedge clk);
                sreq <= 1;
                @(posedge clk);
                sreq <= 0;
                @(negedge clk);
                cmp(areq, 0);
            end else begin
                host.pins(d[3:0]);
                repeat (5) @(negedge clk);
                cmp(gpb, d[3:0]);
                cmp(gpa & gaoe, gao & gaoe);
                cmp(dboe, {gaoe, 8'h00});
                @(posedge clk);
                sreq <= 1;
                swe <= 1;
                swd <= d;
                scmd <= d[1];
                @(posedge clk);
                swe <= 0;
                @(negedge clk);
                cmp({areq, awe, acmd, awd}, {2'h3, d[1], d});
                @(posedge clk);
                sreq <= 0;
                @(negedge clk);
                cmp({areq, awe}, 2'h2);
                repeat (2) @(negedge clk);
                cmp({srv, srd}, {1'b1, ard});
            end
            @(posedge clk);
            sel <= ~sel;
            repeat (6) @(negedge clk);
            cmp(mode, emode(s[2:0]));
        end
        for (g = 0; g < 4; g++) begin
            @(posedge clk);
            pld <= 3'h1 << (g % 3);
            pm <= 8'($random(seed)) & 8'hfc;
            pn <= g == 3 ? 8'h0 : 8'h1 << (g & 1);
            pod <= 8'h1 << (g >> 1);
            @(posedge clk);
            pld <= 0;
            repeat (3) @(negedge clk);
            cmp(opm[(g % 3) * 8 +: 8], pm);
            cmp(opn[(g % 3) * 8 +: 8], pn);
            cmp(opod[(g % 3) * 8 +: 8], pod);
            cmp(fout[(g % 3) * 24 +: 24], efout(pm, pn, pod));
        end
        tally_and_finish;
    end
endmodule
